// >>> mag_core.v
// mode-dependent address generation, register widths and memory models
//
// Overview of operation
// - long mode: 64-bit linear, 40-bit physical, width reported
// - sixteen 64-bit general registers
// - byte access takes lowest 8 bits
// - wide flags: upper 32 reserved, lower legacy
// - instruction pointer is 64 bits
// - stack pointer fixed 64 bits in long mode
// - control and debug 64 bits, priority register
// - table base registers hold full 64-bit base
// - byte addressed memory, 32-bit physical without extension, 36-bit with it
// - flat model spans 0 to 2^32-1
// - selector plus offset, 16383 segments, 2^32 each
// - hardware translates logical to linear
// - real model: 64K segments, 2^20 space
// - paging off: linear passes unchanged
// - paging on: pages, extended and large options
// - long mode maps only through extended paging
// - real mode real model; protected any model
// - long mode segment bases zero, flat only
// - 16-bit limit ffff, 32-bit limit 2^32-1
// - far pointer selector with 32 or 16 offset
// - code segment sets sizes, prefix overrides one
// - real mode 16-bit default, limit 000fffff
`timescale 1ns/10ps
`default_nettype none
`include "mag_defines.vh"
module mag_core #(
  parameter PHYS_W = 40,
  parameter NREG   = 16
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata_ff,
  // memory bus side
  output reg  [63:0] phys_addr_ff,
  output reg         phys_valid_ff,
  output reg         addr_fault_ff
);

  // four descriptor tables: global, interrupt, local and task state
  localparam NTBL = 4;

  // programming state
  reg [1:0]  mode_ff;
  reg [1:0]  model_ff;
  reg [2:0]  cs_attr_ff;
  reg [2:0]  paging_ff;
  reg [15:0] sel_ff;
  reg [63:0] offs_ff;
  reg [63:0] seg_base_ff;
  reg [63:0] page_base_ff;
  reg [3:0]  gpr_idx_ff;
  reg [63:0] flags_ff;
  reg [3:0]  prio_ff;
  reg        go_ff;
  reg [63:0] gpr_ff [0:NREG-1];
  reg [63:0] ip_ff;
  reg [63:0] sp_ff;
  reg [63:0] ctrl_ff;
  reg [63:0] dbg_ff;
  reg [1:0]  tbl_idx_ff;
  reg [63:0] tbl_base_ff [0:NTBL-1];
  reg [15:0] tbl_lim_ff [0:NTBL-1];

  // derived sizes
  reg        addr32;
  reg        op32;
  reg [63:0] limit;
  reg [63:0] lin;
  reg [63:0] phys;
  reg        fault;
  reg [1:0]  eff_model;
  reg [63:0] off_cut;
  wire       long_mode;

  // long mode widens the pointer and system registers
  assign long_mode = (mode_ff == `MAG_MODE_LONG);

  // sizes from code segment attribute, prefixes flip for one access
  always @* begin
    if (mode_ff == `MAG_MODE_REAL) begin
      addr32 = cs_attr_ff[`MAG_CS_AOVR_BIT];
      op32   = cs_attr_ff[`MAG_CS_OOVR_BIT];
    end else begin
      addr32 = cs_attr_ff[`MAG_CS_DEF32_BIT] ^ cs_attr_ff[`MAG_CS_AOVR_BIT];
      op32   = cs_attr_ff[`MAG_CS_DEF32_BIT] ^ cs_attr_ff[`MAG_CS_OOVR_BIT];
    end
  end

  // memory model allowed per mode
  always @* begin
    case (mode_ff)
      `MAG_MODE_REAL:   eff_model = `MAG_MODEL_REAL;
      `MAG_MODE_LONG:   eff_model = `MAG_MODEL_FLAT;
      default:          eff_model = model_ff;
    endcase
  end

  // logical to linear translation, no software involvement
  always @* begin
    fault   = 1'b0;
    limit   = `MAG_LIM32;
    off_cut = addr32 ? {32'h0, offs_ff[31:0]} : {48'h0, offs_ff[15:0]};
    lin     = 64'h0;
    if (mode_ff == `MAG_MODE_LONG) begin
      lin = offs_ff;
    end else if (eff_model == `MAG_MODEL_REAL) begin
      limit = `MAG_LIM20;
      lin = {44'h0, sel_ff, 4'h0} + {48'h0, off_cut[15:0]};
      if (addr32 && off_cut > {48'h0, 16'hffff})
        fault = 1'b1;
      if (lin > limit)
        fault = 1'b1;
    end else begin
      limit = addr32 ? `MAG_LIM32 : `MAG_LIM16;
      if (eff_model == `MAG_MODEL_SEG) begin
        // carry kept so a base plus offset past 4G faults instead of wrapping
        lin = {31'h0, {1'b0, seg_base_ff[31:0]} + {1'b0, off_cut[31:0]}};
        if (sel_ff[15:2] == 14'h0 || sel_ff[15:2] > `MAG_SEL_MAX)
          fault = 1'b1;
      end else begin
        lin = off_cut;
      end
      // full offset: cutting it first would hide a 16-bit overrun
      if (offs_ff > limit || lin > `MAG_LIM32)
        fault = 1'b1;
    end
  end

  // linear to physical mapping
  // page frame takes base bits 55:32 only, frames below 4G other than frame 0 are not reachable
  always @* begin
    if (mode_ff == `MAG_MODE_LONG) begin
      // page frame from base, offset within 4K page
      phys = {page_base_ff[63:12], lin[11:0]};
    end else if (!paging_ff[`MAG_PG_EN_BIT]) begin
      phys = lin;
    end else if (paging_ff[`MAG_PG_LARGE_BIT]) begin
      phys = {page_base_ff[63:22], lin[21:0]};
    end else begin
      phys = {page_base_ff[63:12], lin[11:0]};
    end
  end

  // physical width mask: 40 bits long, 36 with extension, else 32
  wire [63:0] phys_mask;
  assign phys_mask = (mode_ff == `MAG_MODE_LONG) ? ((64'h1 << PHYS_W) - 64'h1) :
                     (paging_ff[`MAG_PG_EXT_BIT] & paging_ff[`MAG_PG_EN_BIT]) ?
                     64'h0000_000f_ffff_ffff : 64'h0000_0000_ffff_ffff;

  // selected general register
  wire [63:0] gpr_sel;
  assign gpr_sel = gpr_ff[gpr_idx_ff];

  // selected descriptor table entry
  wire [63:0] tbl_sel;
  wire [15:0] tbl_lim_sel;
  assign tbl_sel     = tbl_base_ff[tbl_idx_ff];
  assign tbl_lim_sel = tbl_lim_ff[tbl_idx_ff];

  // general registers, one write port each
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_gpr
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          gpr_ff[gi] <= 64'h0;
        end else if (wr && gpr_idx_ff == gi) begin
          if (addr == `MAG_OFF_GPR_LO)
            gpr_ff[gi][31:0] <= op32 ? wdata : {gpr_ff[gi][31:16], wdata[15:0]};
          else if (addr == `MAG_OFF_GPR_HI)
            gpr_ff[gi][63:32] <= wdata;
          else if (addr == `MAG_OFF_GPR_BYTE)
            gpr_ff[gi][7:0] <= wdata[7:0];
        end
      end
    end
  endgenerate

  // instruction and stack pointers, upper halves live only in long mode
  // outside long mode the default size bit stands in for the stack size bit
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ip_ff <= 64'h0;
      sp_ff <= 64'h0;
    end else if (wr) begin
      case (addr)
        `MAG_OFF_IP_LO: begin
          ip_ff[31:0] <= wdata;
          // a stale upper half from long mode must not survive
          if (!long_mode)
            ip_ff[63:32] <= 32'h0;
        end
        `MAG_OFF_IP_HI: begin
          // outside long mode the write is dropped
          if (long_mode)
            ip_ff[63:32] <= wdata;
        end
        `MAG_OFF_SP_LO: begin
          // prefixes never reach the stack pointer
          if (long_mode)
            sp_ff[31:0] <= wdata;
          else if (cs_attr_ff[`MAG_CS_DEF32_BIT])
            sp_ff <= {32'h0, wdata};
          else
            sp_ff <= {32'h0, sp_ff[31:16], wdata[15:0]};
        end
        `MAG_OFF_SP_HI: begin
          // outside long mode the write is dropped
          if (long_mode)
            sp_ff[63:32] <= wdata;
        end
        default: ;
      endcase
    end
  end

  // control and debug registers, 64 bits wide in long mode only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= 64'h0;
      dbg_ff  <= 64'h0;
    end else if (wr) begin
      case (addr)
        `MAG_OFF_CTRL_LO: ctrl_ff[31:0] <= wdata;
        // outside long mode the upper half is forced to zero
        `MAG_OFF_CTRL_HI: ctrl_ff[63:32] <= long_mode ? wdata : 32'h0;
        `MAG_OFF_DBG_LO:  dbg_ff[31:0] <= wdata;
        `MAG_OFF_DBG_HI:  dbg_ff[63:32] <= long_mode ? wdata : 32'h0;
        default: ;
      endcase
    end
  end

  // descriptor table bases, one entry per table, picked by the index register
  // only the global and interrupt tables carry a limit: ten bytes each
  genvar ti;
  generate
    for (ti = 0; ti < NTBL; ti = ti + 1) begin : g_tbl
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          tbl_base_ff[ti] <= 64'h0;
          tbl_lim_ff[ti]  <= 16'h0;
        end else if (wr && tbl_idx_ff == ti) begin
          // both base halves writable in any mode, a full 64-bit base
          if (addr == `MAG_OFF_TBL_LO)
            tbl_base_ff[ti][31:0] <= wdata;
          else if (addr == `MAG_OFF_TBL_HI)
            tbl_base_ff[ti][63:32] <= wdata;
          else if (addr == `MAG_OFF_TBL_LIM && ti < 2)
            tbl_lim_ff[ti] <= wdata[15:0];
        end
      end
    end
  endgenerate

  // register writes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff      <= `MAG_RST_MODE;
      model_ff     <= `MAG_MODEL_FLAT;
      cs_attr_ff   <= 3'h0;
      paging_ff    <= 3'h0;
      sel_ff       <= 16'h0;
      offs_ff      <= 64'h0;
      seg_base_ff  <= 64'h0;
      page_base_ff <= 64'h0;
      gpr_idx_ff   <= 4'h0;
      tbl_idx_ff   <= 2'h0;
      flags_ff     <= `MAG_RST_FLAGS;
      prio_ff      <= 4'h0;
      go_ff        <= 1'b0;
    end else begin
      go_ff <= 1'b0;
      if (wr) begin
        case (addr)
          `MAG_OFF_MODE: begin
            mode_ff  <= wdata[1:0];
            model_ff <= wdata[5:4];
          end
          `MAG_OFF_CS_ATTR:     cs_attr_ff <= wdata[2:0];
          `MAG_OFF_PAGING:      paging_ff <= wdata[2:0];
          `MAG_OFF_SEL:         sel_ff <= wdata[15:0];
          `MAG_OFF_OFFS_LO:     offs_ff[31:0] <= wdata;
          `MAG_OFF_OFFS_HI: begin
            offs_ff[63:32] <= wdata;
            go_ff <= 1'b1;  // high half write launches
          end
          `MAG_OFF_SEG_BASE_LO: seg_base_ff[31:0] <= wdata;
          `MAG_OFF_SEG_BASE_HI: seg_base_ff[63:32] <= wdata;
          `MAG_OFF_PAGE_BASE:   page_base_ff[63:32] <= {8'h0, wdata[31:8]};
          `MAG_OFF_GPR_IDX:     gpr_idx_ff <= wdata[3:0];
          `MAG_OFF_TBL_IDX:     tbl_idx_ff <= wdata[1:0];
          `MAG_OFF_FLAGS_LO:    flags_ff[31:0] <= wdata | 32'h2;
          `MAG_OFF_FLAGS_HI:    flags_ff[63:32] <= 32'h0;
          `MAG_OFF_PRIO:        prio_ff <= wdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // translated address driven to memory bus
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phys_addr_ff  <= 64'h0;
      phys_valid_ff <= 1'b0;
      addr_fault_ff <= 1'b0;
    end else begin
      phys_valid_ff <= go_ff & ~fault;
      if (go_ff) begin
        phys_addr_ff  <= phys & phys_mask;
        addr_fault_ff <= fault;
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0;
    end else if (rd) begin
      case (addr)
        `MAG_OFF_MODE:        rdata_ff <= {26'h0, eff_model, 2'h0, mode_ff};
        `MAG_OFF_CS_ATTR:     rdata_ff <= {29'h0, cs_attr_ff};
        `MAG_OFF_PAGING:      rdata_ff <= {29'h0, paging_ff};
        `MAG_OFF_SEL:         rdata_ff <= {16'h0, sel_ff};
        `MAG_OFF_OFFS_LO:     rdata_ff <= offs_ff[31:0];
        `MAG_OFF_OFFS_HI:     rdata_ff <= offs_ff[63:32];
        `MAG_OFF_SEG_BASE_LO: rdata_ff <= seg_base_ff[31:0];
        `MAG_OFF_SEG_BASE_HI: rdata_ff <= seg_base_ff[63:32];
        `MAG_OFF_PHYS_LO:     rdata_ff <= phys_addr_ff[31:0];
        `MAG_OFF_PHYS_HI:     rdata_ff <= phys_addr_ff[63:32];
        `MAG_OFF_STATUS:      rdata_ff <= {28'h0, op32, addr32, phys_valid_ff, addr_fault_ff};
        `MAG_OFF_IDENT:       rdata_ff <= {24'h0, (mode_ff == `MAG_MODE_LONG) ?
                                           `MAG_PHYS_W_LONG : `MAG_PHYS_W_LEGACY};
        `MAG_OFF_GPR_IDX:     rdata_ff <= {28'h0, gpr_idx_ff};
        `MAG_OFF_GPR_LO:      rdata_ff <= gpr_sel[31:0];
        `MAG_OFF_GPR_HI:      rdata_ff <= gpr_sel[63:32];
        `MAG_OFF_GPR_BYTE:    rdata_ff <= {24'h0, gpr_sel[7:0]};
        `MAG_OFF_FLAGS_LO:    rdata_ff <= flags_ff[31:0];
        `MAG_OFF_FLAGS_HI:    rdata_ff <= 32'h0;
        `MAG_OFF_PRIO:        rdata_ff <= {28'h0, prio_ff};
        `MAG_OFF_PAGE_BASE:   rdata_ff <= {page_base_ff[55:32], 8'h0};
        // pointer and system registers
        `MAG_OFF_IP_LO:       rdata_ff <= ip_ff[31:0];
        `MAG_OFF_IP_HI:       rdata_ff <= ip_ff[63:32];
        `MAG_OFF_SP_LO:       rdata_ff <= sp_ff[31:0];
        `MAG_OFF_SP_HI:       rdata_ff <= sp_ff[63:32];
        `MAG_OFF_CTRL_LO:     rdata_ff <= ctrl_ff[31:0];
        `MAG_OFF_CTRL_HI:     rdata_ff <= ctrl_ff[63:32];
        `MAG_OFF_DBG_LO:      rdata_ff <= dbg_ff[31:0];
        `MAG_OFF_DBG_HI:      rdata_ff <= dbg_ff[63:32];
        `MAG_OFF_TBL_IDX:     rdata_ff <= {30'h0, tbl_idx_ff};
        `MAG_OFF_TBL_LIM:     rdata_ff <= {16'h0, tbl_lim_sel};
        `MAG_OFF_TBL_LO:      rdata_ff <= tbl_sel[31:0];
        `MAG_OFF_TBL_HI:      rdata_ff <= tbl_sel[63:32];
        default:              rdata_ff <= 32'h0;
      endcase
    end else begin
      rdata_ff <= 32'h0;
    end
  end

endmodule
`default_nettype wire

// >>> mag_defines.vh
// constants for the mode and address generation block
`ifndef MAG_DEFINES_VH
`define MAG_DEFINES_VH
// register offsets on the plain port
`define MAG_OFF_MODE        8'h00
`define MAG_OFF_CS_ATTR     8'h04
`define MAG_OFF_PAGING      8'h08
`define MAG_OFF_SEL         8'h0c
`define MAG_OFF_OFFS_LO     8'h10
`define MAG_OFF_OFFS_HI     8'h14
`define MAG_OFF_SEG_BASE_LO 8'h18
`define MAG_OFF_SEG_BASE_HI 8'h1c
`define MAG_OFF_PHYS_LO     8'h20
`define MAG_OFF_PHYS_HI     8'h24
`define MAG_OFF_STATUS      8'h28
`define MAG_OFF_IDENT       8'h2c
`define MAG_OFF_GPR_IDX     8'h30
`define MAG_OFF_GPR_LO      8'h34
`define MAG_OFF_GPR_HI      8'h38
`define MAG_OFF_GPR_BYTE    8'h3c
`define MAG_OFF_FLAGS_LO    8'h40
`define MAG_OFF_FLAGS_HI    8'h44
`define MAG_OFF_PRIO        8'h48
`define MAG_OFF_PAGE_BASE   8'h4c
`define MAG_OFF_IP_LO       8'h50
`define MAG_OFF_IP_HI       8'h54
`define MAG_OFF_SP_LO       8'h58
`define MAG_OFF_SP_HI       8'h5c
`define MAG_OFF_CTRL_LO     8'h60
`define MAG_OFF_CTRL_HI     8'h64
`define MAG_OFF_DBG_LO      8'h68
`define MAG_OFF_DBG_HI      8'h6c
`define MAG_OFF_TBL_IDX     8'h70
`define MAG_OFF_TBL_LIM     8'h74
`define MAG_OFF_TBL_LO      8'h78
`define MAG_OFF_TBL_HI      8'h7c
// operating modes
`define MAG_MODE_REAL       2'h0
`define MAG_MODE_PROT       2'h1
`define MAG_MODE_COMPAT     2'h2
`define MAG_MODE_LONG       2'h3
// memory models
`define MAG_MODEL_FLAT      2'h0
`define MAG_MODEL_SEG       2'h1
`define MAG_MODEL_REAL      2'h2
// field positions
`define MAG_CS_DEF32_BIT    0
`define MAG_CS_AOVR_BIT     1
`define MAG_CS_OOVR_BIT     2
`define MAG_PG_EN_BIT       0
`define MAG_PG_EXT_BIT      1
`define MAG_PG_LARGE_BIT    2
// address limits
`define MAG_LIM16           64'h0000_0000_0000_ffff
`define MAG_LIM32           64'h0000_0000_ffff_ffff
`define MAG_LIM20           64'h0000_0000_000f_ffff
`define MAG_SEL_MAX         16'h3fff
// reset values
`define MAG_RST_MODE        2'h0
`define MAG_RST_FLAGS       64'h0000_0000_0000_0002
// widths
`define MAG_PHYS_W_LONG     8'h28
`define MAG_PHYS_W_LEGACY   8'h24
`endif

// >>> mag_mem_model.sv
// physical memory model that logs what the bus hands it
`timescale 1ns/10ps
`default_nettype none
module mag_mem (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // processor bus
  input  wire logic [63:0] phys_addr,
  input  wire logic        phys_valid,
  // observation
  output var  logic [63:0] last_addr,
  output var  logic [15:0] n_acc
);
  // a faulted access must never reach memory, so only valid ones count
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      last_addr <= 64'h0;
      n_acc <= 16'h0;
    end else if (phys_valid) begin
      last_addr <= phys_addr;
      n_acc <= n_acc + 16'h1;
    end
  end
endmodule
`default_nettype wire

// >>> mag_monitor.sv
// checker for the mode and address generation block
`timescale 1ns/10ps
`default_nettype none
`include "mag_defines.vh"
module mag_monitor #(
  parameter PHYS_W = 40
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register port
  input wire logic [7:0]  addr,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata_ff,
  // memory side
  input wire logic [63:0] phys_addr_ff,
  input wire logic        phys_valid_ff,
  input wire logic        addr_fault_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // writing the high offset word starts a translation
  sequence launch_s;
    wr && addr == `MAG_OFF_OFFS_HI;
  endsequence
  // exactly one outcome two edges later
  sequence outcome_s;
    ##2 (phys_valid_ff ^ addr_fault_ff);
  endsequence
  chk_launch_outcome: assert property (launch_s |-> outcome_s)
    else $error("translation gave no single outcome");
  chk_valid_cause: assert property (phys_valid_ff |-> $past(wr && addr == `MAG_OFF_OFFS_HI, 2))
    else $error("valid without launch");
  chk_result_hold: assert property (!$past(wr && addr == `MAG_OFF_OFFS_HI, 2)
    |-> $stable(phys_addr_ff) && $stable(addr_fault_ff))
    else $error("result moved without launch");
  chk_phys_width: assert property ((phys_addr_ff >> PHYS_W) == 64'h0)
    else $error("physical address too wide");
  chk_flags_upper: assert property (rd && addr == `MAG_OFF_FLAGS_HI |=> rdata_ff == 32'h0)
    else $error("upper flags not zero");
  chk_flags_fixed: assert property (rd && addr == `MAG_OFF_FLAGS_LO |=> rdata_ff[1])
    else $error("fixed flag bit clear");
  chk_ident_width: assert property (rd && addr == `MAG_OFF_IDENT
    |=> rdata_ff == 32'h28 || rdata_ff == 32'h24)
    else $error("bad width report");
  chk_byte_low: assert property (rd && addr == `MAG_OFF_GPR_BYTE |=> rdata_ff[31:8] == 24'h0)
    else $error("byte read too wide");
  chk_prio_width: assert property (rd && addr == `MAG_OFF_PRIO |=> rdata_ff[31:4] == 28'h0)
    else $error("priority too wide");
endmodule
bind mag_core mag_monitor #(.PHYS_W(PHYS_W)) mag_monitor_i (.clk(clk), .rst(rst), .addr(addr),
  .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .phys_addr_ff(phys_addr_ff),
  .phys_valid_ff(phys_valid_ff), .addr_fault_ff(addr_fault_ff));
`default_nettype wire

// >>> tb_mode_address_generation.sv
// self-checking bench for the mode and address generation block
`timescale 1ns/10ps
`default_nettype none
`include "mag_defines.vh"
module tb_mode_address_generation;
  logic        clk, rst, wr, rd, p_rd, phys_valid_ff, addr_fault_ff;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata_ff, seed;
  logic [63:0] phys_addr_ff, last_addr;
  logic [15:0] n_acc;
  logic [1:0]  lp;
  logic [64:0] t;
  logic [31:0] rq[$];
  logic [64:0] tq[$];
  logic [31:0] g[16];
  int          errors, n_checks;
  mag_core mag_core_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_ff(rdata_ff), .phys_addr_ff(phys_addr_ff), .phys_valid_ff(phys_valid_ff),
    .addr_fault_ff(addr_fault_ff));
  mag_mem mag_mem_i (.clk(clk), .rst(rst), .phys_addr(phys_addr_ff),
    .phys_valid(phys_valid_ff), .last_addr(last_addr), .n_acc(n_acc));
  task automatic report_and_stop();
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one bus cycle per edge; on a read d is the expected data
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    if (r) rq.push_back(d);
  endtask
  // config first, then offset low and high; idles keep config still while it works
  task automatic xl(input logic [7:0] md, cs, input logic [15:0] sel, input logic [31:0] off,
                    input logic f, input logic [63:0] pa);
    bus(1, 0, `MAG_OFF_MODE, {24'h0, md});
    bus(1, 0, `MAG_OFF_CS_ATTR, {24'h0, cs});
    bus(1, 0, `MAG_OFF_SEL, {16'h0, sel});
    bus(1, 0, `MAG_OFF_OFFS_LO, off);
    tq.push_back({f, pa});
    bus(1, 0, `MAG_OFF_OFFS_HI, 32'h0);
    repeat (3) bus(0, 0, 8'h0, 32'h0);
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // note when results are due: one cycle after a read, two cycles after a launch
  always @(posedge clk) begin
    if (rst) begin
      p_rd <= 1'b0;
      lp <= 2'h0;
    end else begin
      p_rd <= rd;
      lp <= {lp[0], wr && addr == `MAG_OFF_OFFS_HI};
    end
  end
  // sample mid-cycle so the launching edge has settled
  always @(negedge clk) begin
    if (p_rd) check({32'h0, rdata_ff}, {32'h0, rq.pop_front()});
    if (lp[1]) begin
      t = tq.pop_front();
      check({62'h0, addr_fault_ff, phys_valid_ff}, {62'h0, t[64], !t[64]});
      if (!t[64]) check(phys_addr_ff, t[63:0]);
    end
  end
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    errors++;
    report_and_stop();
  end
  initial begin
    {rst, wr, rd, addr, wdata} = {1'b1, 42'h0};
    seed = 32'h61;
    repeat (2) @(posedge clk);
    rst <= 0;
    bus(0, 1, `MAG_OFF_MODE, 32'h20);
    bus(0, 1, `MAG_OFF_FLAGS_LO, 32'h2);
    bus(0, 1, 8'h80, 32'h0);
    bus(1, 0, `MAG_OFF_PAGING, 32'h0);
    bus(1, 0, `MAG_OFF_PAGE_BASE, 32'h0);
    bus(1, 0, `MAG_OFF_SEG_BASE_LO, 32'h1000);
    bus(1, 0, `MAG_OFF_SEG_BASE_HI, 32'h0);
    xl(8'h00, 8'h0, 16'h1234, 32'h10, 0, 64'h12350);
    xl(8'h00, 8'h0, 16'hffff, 32'h10, 1, 64'h0);
    xl(8'h01, 8'h1, 16'h0, 32'hffff_fff0, 0, 64'hffff_fff0);
    xl(8'h01, 8'h0, 16'h0, 32'h1_0000, 1, 64'h0);
    xl(8'h01, 8'h2, 16'h0, 32'h1_0000, 0, 64'h1_0000);
    xl(8'h11, 8'h1, 16'h8, 32'h20, 0, 64'h1020);
    xl(8'h11, 8'h1, 16'h3, 32'h20, 1, 64'h0);
    bus(1, 0, `MAG_OFF_PAGING, 32'h3);
    bus(1, 0, `MAG_OFF_PAGE_BASE, 32'h500);
    xl(8'h01, 8'h1, 16'h0, 32'h12_3456, 0, 64'h5_0000_0456);
    bus(1, 0, `MAG_OFF_PAGING, 32'h7);
    xl(8'h01, 8'h1, 16'h0, 32'h12_3456, 0, 64'h5_0012_3456);
    xl(8'h13, 8'h1, 16'h8, 32'h123, 0, 64'h5_0000_0123);
    bus(0, 1, `MAG_OFF_MODE, 32'h03);
    bus(0, 1, `MAG_OFF_IDENT, 32'h28);
    bus(0, 1, `MAG_OFF_PHYS_HI, 32'h5);
    bus(0, 1, `MAG_OFF_PAGE_BASE, 32'h500);
    bus(1, 0, `MAG_OFF_IP_HI, 32'h1);
    bus(1, 0, `MAG_OFF_SP_HI, 32'h2);
    bus(1, 0, `MAG_OFF_CTRL_HI, 32'h3);
    bus(1, 0, `MAG_OFF_TBL_IDX, 32'h1);
    bus(1, 0, `MAG_OFF_TBL_HI, 32'h4);
    bus(1, 0, `MAG_OFF_TBL_LIM, 32'h1_0fff);
    bus(0, 1, `MAG_OFF_IP_HI, 32'h1);
    bus(0, 1, `MAG_OFF_SP_HI, 32'h2);
    bus(0, 1, `MAG_OFF_CTRL_HI, 32'h3);
    bus(0, 1, `MAG_OFF_TBL_HI, 32'h4);
    bus(0, 1, `MAG_OFF_TBL_LIM, 32'hfff);
    bus(1, 0, `MAG_OFF_FLAGS_HI, 32'hffff_ffff);
    bus(0, 1, `MAG_OFF_FLAGS_HI, 32'h0);
    bus(1, 0, `MAG_OFF_FLAGS_LO, 32'h0);
    bus(0, 1, `MAG_OFF_FLAGS_LO, 32'h2);
    bus(1, 0, `MAG_OFF_PRIO, 32'h5a);
    bus(0, 1, `MAG_OFF_PRIO, 32'ha);
    bus(1, 0, `MAG_OFF_MODE, 32'h01);
    bus(0, 1, `MAG_OFF_IDENT, 32'h24);
    bus(1, 0, `MAG_OFF_IP_LO, 32'h5);
    bus(1, 0, `MAG_OFF_SP_LO, 32'h7);
    bus(1, 0, `MAG_OFF_DBG_HI, 32'h6);
    bus(0, 1, `MAG_OFF_IP_HI, 32'h0);
    bus(0, 1, `MAG_OFF_SP_HI, 32'h0);
    bus(0, 1, `MAG_OFF_DBG_HI, 32'h0);
    for (int i = 0; i < 16; i++) begin
      g[i] = xs();
      bus(1, 0, `MAG_OFF_GPR_IDX, 32'(i));
      bus(1, 0, `MAG_OFF_GPR_LO, g[i]);
      bus(1, 0, `MAG_OFF_GPR_HI, ~g[i]);
    end
    for (int i = 0; i < 16; i++) begin
      bus(1, 0, `MAG_OFF_GPR_IDX, 32'(i));
      bus(0, 1, `MAG_OFF_GPR_LO, g[i]);
      bus(0, 1, `MAG_OFF_GPR_HI, ~g[i]);
      bus(0, 1, `MAG_OFF_GPR_BYTE, {24'h0, g[i][7:0]});
    end
    repeat (3) bus(0, 0, 8'h0, 32'h0);
    check({48'h0, n_acc}, 64'h7);
    check(last_addr, 64'h5_0000_0123);
    report_and_stop();
  end
endmodule
`default_nettype wire
